// *** src/scp_regs.vh ***
// Constants for the system control pin block: strap, speed and decode settings.
// Assumes inclusion by the single design module, no registers reachable by software.
`ifndef SCP_REGS_VH
`define SCP_REGS_VH

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SCP_RST_STRAP 1'b1
`define SCP_RST_PERF 1'b1
`define SCP_RST_IRQN 1'b1
`define SCP_RST_CSN 1'b1
`define SCP_RST_SYNC 2'h0
`define SCP_RST_DONE 1'h0
`define SCP_RST_OEN 1'h1
`define SCP_RST_LED 1'h1
`define SCP_RST_STB 1'h0
`define SCP_RST_SMI_CNT 8'h00
`define SCP_RST_LOW 1'h0

// ----------------------------------------
// Address decode
// ----------------------------------------
`define SCP_ROM_BASE 24'h0e0000
`define SCP_ROM_MASK 24'hfe0000
`define SCP_KBC_PORT_A 16'h0060
`define SCP_KBC_PORT_B 16'h0064
`define SCP_RTC_INDEX 16'h0070
`define SCP_RTC_DATA 16'h0071

// ----------------------------------------
// Timing
// ----------------------------------------
`define SCP_CLK_PERIOD_NS 25
`define SCP_SMI_PULSE_NS 100
`define SCP_SMI_PULSE_CYC ((`SCP_SMI_PULSE_NS + `SCP_CLK_PERIOD_NS - 1) / `SCP_CLK_PERIOD_NS)

`endif

// *** src/scp_sys_ctrl.v ***
// System control pin logic: clock strap, clock generator control, power switch,
// speed switch and LED, peripheral chip select, clock address strobe, keyboard inhibit.
// Assumes all inputs are synchronous to ref_clk and that the board supplies the time base.
`timescale 1ns/1ps
`include "scp_regs.vh"

module scp_sys_ctrl #(
	parameter SMI_CYC = `SCP_SMI_PULSE_CYC
) (
	// Clock and reset
	input wire ref_clk,
	input wire nrst,
	// Strap pin, four signals
	input wire clock_strap_or_select_in,
	output reg clock_strap_or_select_out,
	output reg clock_strap_or_select_oe_n,
	output reg rtc_internal_en,
	// Power and speed
	input wire power_down_req,
	input wire pm_switch_in,
	output reg sys_mgmt_irq_n,
	output reg clockgen_perf_ctrl,
	input wire speed_switch_in,
	output reg speed_led_out,
	// Peripheral access
	input wire [23:0] bus_addr,
	input wire mem_cycle,
	input wire io_cycle,
	input wire io_write,
	output reg periph_bus_cs_n,
	output reg clock_addr_strobe,
	// Time base
	input wire timebase_in,
	output reg timebase_xtal_out,
	// Keyboard
	input wire kbc_enable,
	input wire irq1_pin,
	output reg irq1_to_pic,
	output reg kbd_inhibit
);

	// ----------------------------------------
	// Reset release
	// ----------------------------------------
	// Reset asserts at once but leaves only on the second edge, so no
	// register sees a release that falls close to a clock edge.
	reg [1:0] rst_sync_r;
	wire rst_n;

	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rst_sync_r <= `SCP_RST_SYNC;
		end else begin
			rst_sync_r <= {rst_sync_r[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_r[1];

	// ----------------------------------------
	// Decode functions
	// ----------------------------------------
	function is_clock_index;
		input [15:0] a;
		begin
			is_clock_index = (a == `SCP_RTC_INDEX);
		end
	endfunction

	function is_clock_port;
		input [15:0] a;
		input io;
		begin
			is_clock_port = io && (is_clock_index(a) || (a == `SCP_RTC_DATA));
		end
	endfunction

	function is_rom_or_kbc;
		input [23:0] a;
		input m;
		input io;
		begin
			is_rom_or_kbc = (m && ((a & `SCP_ROM_MASK) == `SCP_ROM_BASE)) ||
				(io && ((a[15:0] == `SCP_KBC_PORT_A) || (a[15:0] == `SCP_KBC_PORT_B)));
		end
	endfunction

	// ----------------------------------------
	// Registers and next values
	// ----------------------------------------
	// Each register has its own process below, fed by a combinational next value.
	reg strap_done_r;
	reg strap_done_nxt;
	reg rtc_en_nxt;
	reg sel_oe_n_nxt;
	reg sel_out_nxt;
	reg perf_nxt;
	reg led_nxt;
	reg pm_prev_r;
	reg pm_prev_nxt;
	reg pm_rise;
	reg [7:0] smi_cnt_r;
	reg [7:0] smi_cnt_nxt;
	reg smi_n_nxt;
	reg cs_n_nxt;
	reg stb_nxt;
	reg xtal_nxt;
	reg pic_nxt;
	reg inh_nxt;

	// ----------------------------------------
	// Strap capture
	// ----------------------------------------
	// The pin is only sampled in the first cycle after release; later drive
	// of the pin as a chip select must never feed back into the strap.
	always @* begin
		strap_done_nxt = 1'b1;
		rtc_en_nxt = rtc_internal_en;
		if (!strap_done_r) begin
			rtc_en_nxt = clock_strap_or_select_in;
		end
	end

	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			strap_done_r <= `SCP_RST_DONE;
		end else begin
			strap_done_r <= strap_done_nxt;
		end
	end

	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rtc_internal_en <= `SCP_RST_STRAP;
		end else begin
			rtc_internal_en <= rtc_en_nxt;
		end
	end

	// ----------------------------------------
	// Pin as external clock select
	// ----------------------------------------
	// pin as select
	always @* begin
		sel_oe_n_nxt = !(strap_done_r && !rtc_internal_en);
		sel_out_nxt = !is_clock_port(bus_addr[15:0], io_cycle);
	end

	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			clock_strap_or_select_oe_n <= `SCP_RST_OEN;
		end else begin
			clock_strap_or_select_oe_n <= sel_oe_n_nxt;
		end
	end

	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			clock_strap_or_select_out <= `SCP_RST_CSN;
		end else begin
			clock_strap_or_select_out <= sel_out_nxt;
		end
	end

	// ----------------------------------------
	// Speed and clock generator
	// ----------------------------------------
	// The LED shares the clock generator condition, so it shows the speed in force.
	always @* begin
		perf_nxt = speed_switch_in && !power_down_req;
		led_nxt = perf_nxt;
	end

	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			clockgen_perf_ctrl <= `SCP_RST_PERF;
		end else begin
			clockgen_perf_ctrl <= perf_nxt;
		end
	end

	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			speed_led_out <= `SCP_RST_LED;
		end else begin
			speed_led_out <= led_nxt;
		end
	end

	// ----------------------------------------
	// Power switch interrupt
	// ----------------------------------------
	// A new rising edge restarts the count, so a second press stretches the pulse.
	always @* begin
		pm_prev_nxt = pm_switch_in;
		pm_rise = pm_switch_in && !pm_prev_r;
		smi_cnt_nxt = smi_cnt_r;
		smi_n_nxt = sys_mgmt_irq_n;
		if (pm_rise) begin
			smi_cnt_nxt = SMI_CYC[7:0];
			smi_n_nxt = 1'b0;
		end else if (smi_cnt_r > 8'h01) begin
			smi_cnt_nxt = smi_cnt_r - 8'h01;
		end else begin
			smi_cnt_nxt = 8'h00;
			smi_n_nxt = 1'b1;
		end
	end

	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pm_prev_r <= `SCP_RST_LOW;
		end else begin
			pm_prev_r <= pm_prev_nxt;
		end
	end

	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			smi_cnt_r <= `SCP_RST_SMI_CNT;
		end else begin
			smi_cnt_r <= smi_cnt_nxt;
		end
	end

	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sys_mgmt_irq_n <= `SCP_RST_IRQN;
		end else begin
			sys_mgmt_irq_n <= smi_n_nxt;
		end
	end

	// ----------------------------------------
	// Peripheral decode
	// ----------------------------------------
	// Both selects are registered, so they trail the address by one cycle.
	always @* begin
		cs_n_nxt = !is_rom_or_kbc(bus_addr, mem_cycle, io_cycle);
		stb_nxt = rtc_internal_en && io_cycle && io_write && is_clock_index(bus_addr[15:0]);
	end

	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			periph_bus_cs_n <= `SCP_RST_CSN;
		end else begin
			periph_bus_cs_n <= cs_n_nxt;
		end
	end

	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			clock_addr_strobe <= `SCP_RST_STB;
		end else begin
			clock_addr_strobe <= stb_nxt;
		end
	end

	// ----------------------------------------
	// Time base and keyboard
	// ----------------------------------------
	// The oscillator itself is analog; only the inverted feedback level is modelled.
	always @* begin
		xtal_nxt = !timebase_in;
		pic_nxt = !kbc_enable && irq1_pin;
		inh_nxt = kbc_enable && irq1_pin;
	end

	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			timebase_xtal_out <= `SCP_RST_LOW;
		end else begin
			timebase_xtal_out <= xtal_nxt;
		end
	end

	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq1_to_pic <= `SCP_RST_LOW;
		end else begin
			irq1_to_pic <= pic_nxt;
		end
	end

	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			kbd_inhibit <= `SCP_RST_LOW;
		end else begin
			kbd_inhibit <= inh_nxt;
		end
	end

endmodule // scp_sys_ctrl

// *** testbench/scp_board.sv ***
// Board model: the time base oscillator.
// Assumes it runs free from time zero.
`timescale 1ns/1ps
module scp_board (
	output logic timebase
);
	initial timebase = 1'b0;
	always #15258.789 timebase = ~timebase;
endmodule // scp_board

// *** testbench/scp_sys_chk.sv ***
// Checker of the pin logic, bound to the design module scp_sys_ctrl.
// Assumes the default four-cycle interrupt pulse.
`timescale 1ns/1ps
module scp_sys_chk (
	input wire ref_clk, nrst, power_down_req, pm_switch_in, sys_mgmt_irq_n, speed_led_out,
	input wire clockgen_perf_ctrl, speed_switch_in, mem_cycle, io_cycle, io_write,
	input wire periph_bus_cs_n, clock_addr_strobe, kbc_enable, irq1_pin, kbd_inhibit,
	input wire rtc_internal_en, clock_strap_or_select_oe_n,
	input wire [23:0] bus_addr
);
	// Wait out the reset synchroniser and strap capture before judging.
	logic [2:0] up_r;
	always @(posedge ref_clk or negedge nrst)
		if (!nrst) up_r <= 3'h0;
		else if (up_r != 3'h6) up_r <= up_r + 3'h1;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (up_r != 3'h6);
	sequence smi_low; !sys_mgmt_irq_n [*4]; endsequence
	perf_follow_a: assert property (clockgen_perf_ctrl ==
		$past(speed_switch_in && !power_down_req)) else $error("perf wrong");
	slow_down_a: assert property ($past(power_down_req) |-> !clockgen_perf_ctrl)
		else $error("perf high");
	led_track_a: assert property (speed_led_out == clockgen_perf_ctrl)
		else $error("led wrong");
	smi_pulse_a: assert property ($rose(pm_switch_in) |=> smi_low)
		else $error("smi short");
	smi_cause_a: assert property ($fell(sys_mgmt_irq_n) |->
		$past(pm_switch_in) && !$past(pm_switch_in, 2)) else $error("smi cause");
	cs_decode_a: assert property (periph_bus_cs_n == !$past(mem_cycle &&
		bus_addr[23:17] == 7'h07 || io_cycle && (bus_addr[15:0] == 16'h0060 ||
		bus_addr[15:0] == 16'h0064))) else $error("cs wrong");
	strobe_gen_a: assert property (clock_addr_strobe == $past(io_cycle &&
		io_write && bus_addr[15:0] == 16'h0070 && rtc_internal_en)) else $error("strobe");
	strap_hold_a: assert property ($stable(rtc_internal_en)) else $error("strap");
	pin_dir_a: assert property (clock_strap_or_select_oe_n == rtc_internal_en)
		else $error("pin dir");
	kbd_route_a: assert property (kbd_inhibit == $past(kbc_enable && irq1_pin))
		else $error("kbd");
endmodule // scp_sys_chk
bind scp_sys_ctrl scp_sys_chk chk (.ref_clk(ref_clk), .nrst(nrst),
	.power_down_req(power_down_req), .pm_switch_in(pm_switch_in),
	.sys_mgmt_irq_n(sys_mgmt_irq_n), .speed_led_out(speed_led_out),
	.clockgen_perf_ctrl(clockgen_perf_ctrl), .speed_switch_in(speed_switch_in),
	.mem_cycle(mem_cycle), .io_cycle(io_cycle), .io_write(io_write),
	.periph_bus_cs_n(periph_bus_cs_n), .clock_addr_strobe(clock_addr_strobe),
	.kbc_enable(kbc_enable), .irq1_pin(irq1_pin), .kbd_inhibit(kbd_inhibit),
	.rtc_internal_en(rtc_internal_en),
	.clock_strap_or_select_oe_n(clock_strap_or_select_oe_n), .bus_addr(bus_addr));

// *** testbench/system_control_pins_tb_top.sv ***
// Self-checking bench of the pin logic.
// Assumes the board model and the bound checker.
`timescale 1ns/1ps
module system_control_pins_tb_top;
	logic ref_clk = 0, nrst = 0, strap = 1, pdr = 0, pm = 0, spd = 0, mc = 0, ioc = 0;
	logic iow = 0, kbc = 0, irq1 = 0;
	logic [23:0] addr = 24'h0;
	wire tb, xo, so, oe_n, rtc_en, smi_n, perf, led, cs_n, stb, pic, inh;
	// The strap pull sets the pin unless the device drives it.
	wire pin = oe_n ? strap : so;
	int n_mismatch = 0, check_count = 0, cyc = 0;
	`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_mismatch++; \
		$display("MISMATCH %0t got %b want %b", $time, a, b); end end
	scp_board brd (.timebase(tb));
	scp_sys_ctrl dut (.ref_clk(ref_clk), .nrst(nrst), .clock_strap_or_select_in(pin),
		.clock_strap_or_select_out(so), .clock_strap_or_select_oe_n(oe_n),
		.rtc_internal_en(rtc_en), .power_down_req(pdr), .pm_switch_in(pm),
		.sys_mgmt_irq_n(smi_n), .clockgen_perf_ctrl(perf), .speed_switch_in(spd),
		.speed_led_out(led), .bus_addr(addr), .mem_cycle(mc), .io_cycle(ioc),
		.io_write(iow), .periph_bus_cs_n(cs_n), .clock_addr_strobe(stb),
		.timebase_in(tb), .timebase_xtal_out(xo), .kbc_enable(kbc), .irq1_pin(irq1),
		.irq1_to_pic(pic), .kbd_inhibit(inh));
	always #12.5 ref_clk = ~ref_clk;
	always @(posedge ref_clk) if (++cyc == 5000) begin n_mismatch++; finish_test; end
	task finish_test;
		$display("mismatches %0d checks %0d", n_mismatch, check_count);
		if (n_mismatch == 0 && check_count > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task rst(input logic s);
		strap = s; nrst = 0; repeat (5) @(negedge ref_clk);
		nrst = 1; repeat (6) @(negedge ref_clk);
	endtask
	task t_speed;
		for (int i = 0; i < 4; i++) begin
			{spd, pdr} = i[1:0]; @(negedge ref_clk);
			`CHK(perf, spd & ~pdr)
			`CHK(led, spd & ~pdr)
		end
	endtask
	task t_smi;
		pm = 1; @(negedge ref_clk);
		repeat (4) begin `CHK(smi_n, 1'b0) @(negedge ref_clk); end
		`CHK(smi_n, 1'b1)
		pm = 0;
	endtask
	task t_cs;
		logic [25:0] v[5] = '{{2'b10, 24'h0e0000}, {2'b10, 24'h0fffff},
			{2'b01, 24'h000064}, {2'b10, 24'h0dffff}, {2'b01, 24'h000061}};
		for (int i = 0; i < 5; i++) begin
			{mc, ioc, addr} = v[i]; @(negedge ref_clk);
			`CHK(cs_n, i > 2)
		end
		mc = 0; ioc = 0;
	endtask
	task t_stb(input logic en);
		addr = 24'h000070; ioc = 1; iow = 1; @(negedge ref_clk);
		`CHK(stb, en)
		if (!en) `CHK(so, 1'b0)
		ioc = 0; iow = 0; @(negedge ref_clk);
		`CHK(stb, 1'b0)
	endtask
	task t_kbd;
		for (int i = 0; i < 4; i++) begin
			{kbc, irq1} = i[1:0]; @(negedge ref_clk);
			`CHK(inh, kbc & irq1)
			`CHK(pic, ~kbc & irq1)
		end
	endtask
	task t_strap;
		rst(1'b0);
		`CHK({rtc_en, oe_n}, 2'b00)
		strap = 1; @(negedge ref_clk);
		`CHK(rtc_en, 1'b0)
		t_stb(1'b0);
	endtask
	task t_osc;
		`CHK(xo, ~tb)
		@(posedge tb); repeat (2) @(negedge ref_clk);
		`CHK(xo, ~tb)
	endtask
	initial begin
		rst(1'b1);
		`CHK({rtc_en, oe_n}, 2'b11)
		strap = 0; @(negedge ref_clk);
		`CHK({rtc_en, oe_n}, 2'b11)
		t_speed; t_smi; t_cs; t_stb(1'b1); t_kbd; t_strap; t_osc;
		finish_test;
	end
endmodule // system_control_pins_tb_top
